// ===== bench/fspg_checker_assertions.sv
// port checker for the flash self-program guard
`timescale 1ns/10ps
module fspg_checker #(
  parameter int ADDR_W   = 15,
  parameter int PROG_CYC = 4000
) (
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              clk_en,
  input wire logic [ADDR_W-1:0] pc_addr,
  input wire logic              store_req,
  input wire logic              load_req,
  input wire logic [ADDR_W-1:0] load_addr,
  input wire logic              vectors_in_boot,
  input wire logic              cpu_halt,
  input wire logic              irq_mask,
  input wire logic [15:0]       load_data,
  input wire logic              load_valid,
  input wire logic [15:0]       flash_rdata,
  input wire logic              flash_prog,
  input wire logic [ADDR_W-1:0] flash_prog_addr,
  input wire logic [1:0]        boot_size_fuses
);
  logic [ADDR_W-1:0] base;
  logic [15:0]       len_r;
  logic [15:0]       len_nxt;
  assign base = 15'h4000 - (15'h0100 << (2'h3 - boot_size_fuses));
  always_comb len_nxt = flash_prog ? len_r + 16'h1 : 16'h0;
  always_ff @(posedge clk) len_r <= reset_n ? len_nxt : 16'h0;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  load_answer_a: assert property (clk_en && load_req |=> load_valid)
    else $error("load not answered");
  app_store_off_a: assert property (
    !flash_prog && store_req && pc_addr < base |=> !flash_prog)
    else $error("store from application ran");
  halt_region_a: assert property (
    flash_prog |-> cpu_halt == (flash_prog_addr >= 15'h3800))
    else $error("halt region wrong");
  halt_only_prog_a: assert property (!flash_prog |-> !cpu_halt)
    else $error("halt without programming");
  prog_length_a: assert property (
    $fell(flash_prog) |-> len_r == PROG_CYC) else $error("prog length wrong");
  irq_own_vec_a: assert property (
    (pc_addr >= base) == vectors_in_boot |-> !irq_mask)
    else $error("irq masked wrongly");
  same_sect_load_a: assert property (
    load_req && clk_en && (pc_addr >= base) == (load_addr >= base)
    |=> load_data == $past(flash_rdata)) else $error("load data wrong");
  prog_cause_a: assert property ($rose(flash_prog) |-> $past(store_req))
    else $error("prog without store");
  cover property ($rose(cpu_halt));
  cover property (flash_prog && !cpu_halt);
  cover property (load_valid && load_data == 16'hFFFF);
endmodule
bind fspg_top fspg_checker #(.ADDR_W(ADDR_W), .PROG_CYC(PROG_CYC)) u_chk (.*);

// ===== bench/fspg_cpu_model.sv
// cpu core and flash array model issuing program store and load ops
`timescale 1ns/10ps
module fspg_cpu_model (
  input  wire logic        clk,
  output logic [14:0]      pc_addr,
  output logic             store_req,
  output logic             load_req,
  output logic [14:0]      store_addr,
  output logic [14:0]      load_addr,
  output logic [15:0]      flash_rdata
);
  initial {pc_addr, store_req, load_req, store_addr, load_addr} = '0;
  initial flash_rdata = 16'h0000;
  // one op per call: request stands one cycle, then it is withdrawn
  task automatic op(input logic st, input logic [14:0] pc, a, input int d);
    @(posedge clk);
    pc_addr <= pc;
    store_req <= st;
    load_req <= !st;
    store_addr <= a;
    load_addr <= a;
    flash_rdata <= d[15:0];
    @(posedge clk);
    store_req <= 1'b0;
    load_req <= 1'b0;
    flash_rdata <= ~d[15:0];
  endtask
endmodule

// ===== bench/fspg_testbench.sv
// self-checking bench for the flash self-program guard
`timescale 1ns/10ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin \
  n_mismatch++; $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module testbench;
  localparam int PC = 8;
  logic clk = 0, reset_n = 0, clk_en = 1, chip_erase = 0;
  logic vectors_in_boot = 0, avs_read = 0, avs_write = 0;
  logic [1:0] boot_size_fuses = 2'h3, app, bt;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [14:0] pc_addr, store_addr, load_addr, flash_prog_addr;
  logic [15:0] flash_rdata, load_data;
  logic store_req, load_req, cpu_halt, irq_mask, load_valid, flash_prog;
  logic avs_waitrequest;
  int n_mismatch = 0, compares = 0, seed = 51, cyc = 0;
  int base, pcb, ab, a, d, ok;
  always #12.5 clk = ~clk;
  fspg_top #(.PROG_CYC(PC)) dut (.*);
  fspg_cpu_model cpu (.*);
  task close_out;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      close_out();
    end
  end
  function automatic int pick(int b);
    int r;
    r = $random(seed) & 'h7FFF;
    return b ? base + r % ('h4000 - base) : r % base;
  endfunction
  task automatic av(input logic w, input logic [3:0] ad, input int wd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= ad;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) n_mismatch++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    av(0, 4'h4, 0);
    `CHK("status", 0, q)
    av(0, 4'h8, 0);
    `CHK("lock reset", 'hCC, q & 'hCC)
    av(0, 4'hC, 0);
    `CHK("unmapped", 0, q)
    for (int i = 0; i < 16; i++) begin
      {bt, app} = i[3:0];
      d = $random(seed);
      boot_size_fuses <= d[1:0];
      base = 'h4000 - ('h100 << (3 - d[1:0]));
      chip_erase <= 1'b1;
      @(posedge clk);
      chip_erase <= 1'b0;
      av(1, 4'h8, {bt, 2'h0, app, 2'h0});
      av(1, 4'h8, 'hFF);
      av(0, 4'h8, 0);
      `CHK("lock", {bt, 2'h0, app, 2'h0}, q & 'hCC)
      for (int j = 0; j < 4; j++) begin
        pcb = j % 2;
        ab = j / 2;
        d = $random(seed);
        vectors_in_boot <= ab[0];
        cpu.op(0, pick(pcb), pick(ab), d);
        ok = !(!app[1] && pcb && !ab) && !(!bt[1] && !pcb && ab);
        @(negedge clk);
        `CHK("valid", 1, load_valid)
        `CHK("ldata", ok ? d[15:0] : 'hFFFF, load_data)
        `CHK("irq", (!app[1] && ab && !pcb) || (!bt[1] && !ab && pcb), irq_mask)
      end
      for (int j = 0; j < 3; j++) begin
        pcb = j > 0;
        ab = j == 2;
        a = pick(ab);
        cpu.op(1, pick(pcb), a, 0);
        ok = pcb && !(!app[0] && !ab) && !(!bt[0] && ab);
        @(negedge clk);
        `CHK("prog", ok, flash_prog)
        `CHK("halt", ok && a >= 'h3800, cpu_halt)
        repeat (PC + 1) @(posedge clk);
        av(0, 4'h4, 0);
        `CHK("busy", ok && a < 'h3800, q[0])
        `CHK("refused", !ok, q[3])
        av(1, 4'h0, 1);
        av(0, 4'h4, 0);
        `CHK("cleared", 0, q & 'h9)
      end
    end
    close_out();
  end
endmodule

// ===== rtl/fspg_consts.svh
// constants for the flash self-program guard
// Summary of operation
// - store from application section never starts programming
// - boot-section store may target any flash page
// - halt depends only on programmed page region
// - concurrent region programming keeps CPU running
// - stalling region programming halts CPU throughout
// - boot section always inside stalling region
// - busy bit reads one while region blocked
// - lock bits clear only by chip erase or reset
// - general lock modes never gate self-programming
// - lock bit one unprogrammed, reset unrestricted
// - application pair 11 allows everything
// - application pair 10/00 blocks stores
// - application pair 00 blocks stores and loads
// - application pair 00/01 blocks boot loads
// - application pair 00/01 masks interrupts
// - boot pair 11 allows everything
// - boot pair 10/00 blocks stores
// - boot pair 00/01 blocks application loads
// - boot pair 00/01 masks interrupts
// - boot-size fuses set section boundary
`ifndef FSPG_CONSTS_SVH
`define FSPG_CONSTS_SVH
`define FSPG_ADDR_W       15
`define FSPG_FLASH_WORDS  16'h4000
`define FSPG_STALL_BASE   15'h3800
`define FSPG_BOOT_MAX     15'h0800
`define FSPG_BLOCK_VALUE  16'hFFFF
`define FSPG_LOCK_UNPROG  2'h3
`define FSPG_OFS_CTRL     4'h0
`define FSPG_OFS_STATUS   4'h4
`define FSPG_OFS_LOCK     4'h8
`define FSPG_CTRL_CLRBUSY 0
`define FSPG_CTRL_ERASE   1
`define FSPG_ST_BUSY      0
`define FSPG_ST_HALT      1
`define FSPG_ST_PROG      2
`define FSPG_ST_REFUSED   3
`endif

// ===== rtl/fspg_lock_decode.sv
// decodes one lock-bit pair into its permissions
`timescale 1ns/10ps
module fspg_lock_decode (
  input  wire logic [1:0] lock_pair,
  output logic            store_block,
  output logic            load_block,
  output logic            irq_block
);
  // bit high is unprogrammed; 11 leaves the section open
  always_comb begin
    store_block = ~lock_pair[0];
    load_block  = ~lock_pair[1];
    irq_block   = ~lock_pair[1];
    if (lock_pair == 2'h3) begin
      store_block = 1'b0;
      load_block  = 1'b0;
      irq_block   = 1'b0;
    end
  end
endmodule

// ===== rtl/fspg_pkg.sv
// types for the flash self-program guard
package fspg_pkg;
  typedef enum logic [1:0] {
    FSPG_IDLE  = 2'b00,
    FSPG_PROG  = 2'b01,
    FSPG_DONE  = 2'b10
  } fspg_state_type;
endpackage

// ===== rtl/fspg_top.sv
// access guard and stall control for flash self-programming
`timescale 1ns/10ps
`include "fspg_consts.svh"
module fspg_top
  import fspg_pkg::*;
#(
  parameter int ADDR_W    = `FSPG_ADDR_W,
  parameter int PROG_CYC  = 4000
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  // cpu side
  input  wire logic [ADDR_W-1:0] pc_addr,
  input  wire logic              store_req,
  input  wire logic [ADDR_W-1:0] store_addr,
  input  wire logic              load_req,
  input  wire logic [ADDR_W-1:0] load_addr,
  input  wire logic              vectors_in_boot,
  output logic                   cpu_halt,
  output logic                   irq_mask,
  output logic [15:0]            load_data,
  output logic                   load_valid,
  // flash side
  input  wire logic [15:0]       flash_rdata,
  output logic                   flash_prog,
  output logic [ADDR_W-1:0]      flash_prog_addr,
  input  wire logic [1:0]        boot_size_fuses,
  input  wire logic              chip_erase,
  // avalon-mm slave
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest
);
  localparam logic [ADDR_W-1:0] STALL_BASE = `FSPG_STALL_BASE;
  localparam logic [ADDR_W-1:0] BOOT_MAX   = `FSPG_BOOT_MAX;
  localparam logic [ADDR_W-1:0] TOP_ADDR   = ADDR_W'(`FSPG_FLASH_WORDS - 1);
  localparam int CNT_W = $clog2(PROG_CYC + 1);

  fspg_state_type        state_r, state_nxt;
  logic [CNT_W-1:0]      cnt_r, cnt_nxt;
  logic [ADDR_W-1:0]     paddr_r, paddr_nxt;
  logic                  pstall_r, pstall_nxt;
  logic                  busy_r, busy_nxt;
  logic                  refused_r, refused_nxt;
  logic [1:0]            app_lock_r, app_lock_nxt;
  logic [1:0]            boot_lock_r, boot_lock_nxt;
  logic [15:0]           ldata_r, ldata_nxt;
  logic                  lvalid_r, lvalid_nxt;
  logic [31:0]           rdata_r, rdata_nxt;
  logic                  ack_r, ack_nxt;
  logic [ADDR_W-1:0]     boot_base;
  logic                  pc_boot, st_boot, ld_boot, ld_conc;
  logic                  app_st_blk, app_ld_blk, app_irq_blk;
  logic                  boot_st_blk, boot_ld_blk, boot_irq_blk;
  logic                  store_ok, load_ok;
  logic                  acc;

  // boot section grows down from the top, never below stall base
  always_comb begin
    unique case (boot_size_fuses)
      2'b11:   boot_base = TOP_ADDR - ADDR_W'(15'h00FF);
      2'b10:   boot_base = TOP_ADDR - ADDR_W'(15'h01FF);
      2'b01:   boot_base = TOP_ADDR - ADDR_W'(15'h03FF);
      default: boot_base = TOP_ADDR - (BOOT_MAX - ADDR_W'(1));
    endcase
    if (boot_base < STALL_BASE)
      boot_base = STALL_BASE;
  end

  assign pc_boot = (pc_addr >= boot_base);
  assign st_boot = (store_addr >= boot_base);
  assign ld_boot = (load_addr >= boot_base);
  assign ld_conc = (load_addr < STALL_BASE);

  fspg_lock_decode u_app (
    .lock_pair   (app_lock_r),
    .store_block (app_st_blk),
    .load_block  (app_ld_blk),
    .irq_block   (app_irq_blk)
  );

  fspg_lock_decode u_boot (
    .lock_pair   (boot_lock_r),
    .store_block (boot_st_blk),
    .load_block  (boot_ld_blk),
    .irq_block   (boot_irq_blk)
  );

  // boot and application lock pairs gate self-programming; no general lock input exists
  always_comb begin
    store_ok = pc_boot;
    if (st_boot && boot_st_blk)
      store_ok = 1'b0;
    if (!st_boot && app_st_blk)
      store_ok = 1'b0;
    if (state_r != FSPG_IDLE)
      store_ok = 1'b0;
    load_ok = 1'b1;
    if (pc_boot && !ld_boot && app_ld_blk)
      load_ok = 1'b0;
    if (!pc_boot && ld_boot && boot_ld_blk)
      load_ok = 1'b0;
    if (ld_conc && busy_r)
      load_ok = 1'b0;
  end

  always_comb begin
    irq_mask = 1'b0;
    if (vectors_in_boot && !pc_boot && app_irq_blk)
      irq_mask = 1'b1;
    if (!vectors_in_boot && pc_boot && boot_irq_blk)
      irq_mask = 1'b1;
  end

  assign acc = avs_read | avs_write;

  always_comb begin
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    paddr_nxt     = paddr_r;
    pstall_nxt    = pstall_r;
    busy_nxt      = busy_r;
    refused_nxt   = refused_r;
    app_lock_nxt  = app_lock_r;
    boot_lock_nxt = boot_lock_r;
    ldata_nxt     = ldata_r;
    lvalid_nxt    = 1'b0;
    rdata_nxt     = rdata_r;
    ack_nxt       = 1'b0;
    unique case (state_r)
      FSPG_IDLE: begin
        if (store_req) begin
          if (store_ok) begin
            state_nxt  = FSPG_PROG;
            cnt_nxt    = CNT_W'(PROG_CYC);
            paddr_nxt  = store_addr;
            pstall_nxt = (store_addr >= STALL_BASE);
            if (store_addr < STALL_BASE)
              busy_nxt = 1'b1;
          end else begin
            refused_nxt = 1'b1;
          end
        end
      end
      FSPG_PROG: begin
        if (cnt_r <= CNT_W'(1))
          state_nxt = FSPG_DONE;
        else
          cnt_nxt = cnt_r - CNT_W'(1);
      end
      FSPG_DONE: begin
        state_nxt  = FSPG_IDLE;
        pstall_nxt = 1'b0;
      end
      default: state_nxt = FSPG_IDLE;
    endcase
    if (load_req) begin
      lvalid_nxt = 1'b1;
      if (load_ok) begin
        ldata_nxt = flash_rdata;
      end else begin
        ldata_nxt   = `FSPG_BLOCK_VALUE;
        refused_nxt = 1'b1;
      end
    end
    // avalon slave: one wait cycle, answer on the second
    if (acc && !ack_r) begin
      ack_nxt = 1'b1;
      if (avs_read) begin
        unique case (avs_address)
          `FSPG_OFS_STATUS: rdata_nxt = {28'h0, refused_r,
                                         state_r != FSPG_IDLE,
                                         cpu_halt, busy_r};
          `FSPG_OFS_LOCK:   rdata_nxt = {24'h0, boot_lock_r, 2'h0,
                                         app_lock_r, 2'h0};
          default:          rdata_nxt = 32'h0;
        endcase
      end
    end
    // a write lands at the edge that sees waitrequest low
    if (avs_write && ack_r) begin
      if (avs_address == `FSPG_OFS_CTRL) begin
        if (avs_writedata[`FSPG_CTRL_CLRBUSY] && state_r == FSPG_IDLE
            && !(store_req && store_ok))
          busy_nxt = 1'b0;
        if (avs_writedata[`FSPG_CTRL_ERASE] == 1'b0)
          refused_nxt = 1'b0;
      end else if (avs_address == `FSPG_OFS_LOCK) begin
        // writes may only program bits, never release them
        app_lock_nxt  = app_lock_r & avs_writedata[3:2];
        boot_lock_nxt = boot_lock_r & avs_writedata[7:6];
      end
    end
    // hardware set wins over a software clear in the same cycle
    if (store_req && !store_ok && state_r == FSPG_IDLE)
      refused_nxt = 1'b1;
    if (load_req && !load_ok)
      refused_nxt = 1'b1;
    if (chip_erase) begin
      app_lock_nxt  = `FSPG_LOCK_UNPROG;
      boot_lock_nxt = `FSPG_LOCK_UNPROG;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r     <= FSPG_IDLE;
      cnt_r       <= '0;
      paddr_r     <= '0;
      pstall_r    <= 1'b0;
      busy_r      <= 1'b0;
      refused_r   <= 1'b0;
      app_lock_r  <= `FSPG_LOCK_UNPROG;
      boot_lock_r <= `FSPG_LOCK_UNPROG;
      ldata_r     <= 16'h0000;
      lvalid_r    <= 1'b0;
      rdata_r     <= 32'h0000_0000;
      ack_r       <= 1'b0;
    end else if (clk_en) begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      paddr_r     <= paddr_nxt;
      pstall_r    <= pstall_nxt;
      busy_r      <= busy_nxt;
      refused_r   <= refused_nxt;
      app_lock_r  <= app_lock_nxt;
      boot_lock_r <= boot_lock_nxt;
      ldata_r     <= ldata_nxt;
      lvalid_r    <= lvalid_nxt;
      rdata_r     <= rdata_nxt;
      ack_r       <= ack_nxt;
    end
  end

  assign cpu_halt        = pstall_r && (state_r == FSPG_PROG);
  assign flash_prog      = (state_r == FSPG_PROG);
  assign flash_prog_addr = paddr_r;
  assign load_data       = ldata_r;
  assign load_valid      = lvalid_r;
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = acc & ~ack_r;
endmodule
